//--- dcsr_pkg.sv
/*
 * Shared constants of the disk controller control/status word: bit
 * positions, field widths, function and fault encodings, reset value.
 * Assumes a single-clock design; nothing here holds logic.
 */
package dcsr_pkg;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned FUNC_W     = 3;
	localparam int unsigned UNIT_W     = 2;
	localparam int unsigned MEMHI_W    = 2;
	localparam int unsigned FAULT_W    = 4;
	localparam int unsigned SYNC_DEPTH = 3;

	// bit positions inside the control/status word
	localparam int unsigned BIT_DRIVE_IDLE = 0;
	localparam int unsigned BIT_FUNC_LO    = 1;
	localparam int unsigned BIT_FUNC_HI    = 3;
	localparam int unsigned BIT_MEMHI_LO   = 4;
	localparam int unsigned BIT_MEMHI_HI   = 5;
	localparam int unsigned BIT_IE         = 6;
	localparam int unsigned BIT_CTRL_IDLE  = 7;
	localparam int unsigned BIT_UNIT_LO    = 8;
	localparam int unsigned BIT_UNIT_HI    = 9;
	localparam int unsigned BIT_FAULT_LO   = 10;
	localparam int unsigned BIT_FAULT_HI   = 13;
	localparam int unsigned BIT_DRIVE_ERR  = 14;
	localparam int unsigned BIT_ANY_ERR    = 15;

	// function code encodings
	localparam logic [2:0] FUNC_NOP         = 3'h0;
	localparam logic [2:0] FUNC_WRITE_CHECK = 3'h1;
	localparam logic [2:0] FUNC_GET_STATUS  = 3'h2;
	localparam logic [2:0] FUNC_SEEK        = 3'h3;
	localparam logic [2:0] FUNC_READ_HEADER = 3'h4;
	localparam logic [2:0] FUNC_WRITE_DATA  = 3'h5;
	localparam logic [2:0] FUNC_READ_DATA   = 3'h6;
	localparam logic [2:0] FUNC_READ_NOHDR  = 3'h7;

	// fault code encodings
	localparam logic [3:0] FAULT_NONE              = 4'h0;
	localparam logic [3:0] FAULT_OPERATION_INCOMPL = 4'h1;
	localparam logic [3:0] FAULT_DATA_CHECKSUM     = 4'h2;
	localparam logic [3:0] FAULT_HEADER_CHECKSUM   = 4'h3;
	localparam logic [3:0] FAULT_TRANSFER_OVERRUN  = 4'h4;
	localparam logic [3:0] FAULT_SECTOR_ID_MISSING = 4'h5;
	localparam logic [3:0] FAULT_MISSING_MEMORY    = 4'h8;
	localparam logic [3:0] FAULT_MEMORY_PARITY     = 4'h9;

	localparam logic [1:0] MEMHI_STEP    = 2'h1;
	localparam logic       CTRL_IDLE_RST = 1'b1;
endpackage

//--- dcsr_pin_sync.sv
/*
 * Three-stage pin synchroniser; a new level is accepted only once the
 * second and third stages agree.
 * Assumes asynchronous inputs and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module dcsr_pin_sync #(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	// pins and clean levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] level_r;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			meta_r   <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
		end else begin
			meta_r   <= pin_in;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					level_r[i] <= 1'b0;
				end else if (stage2_r[i] == stage3_r[i]) begin
					level_r[i] <= stage3_r[i];
				end
			end
		end
	endgenerate

	assign level_out = level_r;
endmodule

//--- dcsr_control_status.sv
/*
 * Control/status word of a cartridge disk controller: command handshake,
 * unit select, address extension bits, fault reporting.
 * Assumes a 16-bit word port from the host bus decoder, a command engine
 * that pulses cmd_done_in once per started command, and drive pins.
 */
// Notes on behaviour
// - three-bit function code in bits 1-3, eight documented commands
// - initialisation clears bits 1-6 and 8-13, sets ready bit 7
// - bit 0 shows drive idle; low from seek start until completion
// - memory pointer carry increments bits 4-5
// - bits 4-5 read/write as data, drive address bits 16-17
// - interrupt on command end when interrupt enable bit 6 set
// - software clearing bit 7 starts the coded command
// - hardware sets bit 7 when command finished and ready again
// - bits 8-9 select the drive unit on the drive bus
// - four-bit fault code in bits 10-13
// - bit 14 follows the drive fault line
// - get status with disk address bit 3 clears drive fault
// - bit 15 is OR of bits 10 through 14
// - error end sets bit 7 and interrupts if enabled
`timescale 1ns/100ps
module dcsr_control_status (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	// word register port
	input  wire logic        csr_wr_en_in,
	input  wire logic [15:0] csr_wr_data_in,
	output logic      [15:0] csr_rd_data_out,
	// command engine
	input  wire logic        cmd_done_in,
	input  wire logic [3:0]  cmd_fault_code_in,
	input  wire logic        ptr_carry_in,
	input  wire logic        disk_address_bit3_in,
	output logic             cmd_start_out,
	output logic      [2:0]  function_code_out,
	output logic      [1:0]  memory_pointer_hi_out,
	output logic             irq_request_out,
	output logic             controller_idle_out,
	// drive bus
	input  wire logic        drive_idle_in,
	input  wire logic        drive_fault_line_in,
	output logic      [1:0]  unit_select_out,
	output logic             drive_fault_clear_out
);
	logic [dcsr_pkg::FUNC_W-1:0]  function_code_r;
	logic [dcsr_pkg::MEMHI_W-1:0] mem_hi_r;
	logic                         interrupt_enable_r;
	logic                         controller_idle_r;
	logic [dcsr_pkg::UNIT_W-1:0]  unit_select_r;
	logic [dcsr_pkg::FAULT_W-1:0] fault_code_r;
	logic                         seek_busy_r;
	logic                         cmd_start_r;
	logic                         fault_clear_r;
	logic                         irq_r;
	logic [dcsr_pkg::WORD_W-1:0]  rd_data_r;
	logic [dcsr_pkg::WORD_W-1:0]  word_nxt;
	logic [1:0]                   pins_clean;
	logic                         go_c;
	logic [2:0]                   wr_func_c;

	dcsr_pin_sync #(
		.WIDTH     (2)
	) u_pin_sync (
		.ref_clk_in(ref_clk_in),
		.reset_in  (reset_in),
		.pin_in    ({drive_fault_line_in, drive_idle_in}),
		.level_out (pins_clean)
	);

	assign wr_func_c = csr_wr_data_in[dcsr_pkg::BIT_FUNC_HI:
		dcsr_pkg::BIT_FUNC_LO];
	// a finishing command owns this cycle; a go written now is not new
	assign go_c = csr_wr_en_in && !csr_wr_data_in[dcsr_pkg::BIT_CTRL_IDLE]
		&& controller_idle_r && !cmd_done_in;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			function_code_r    <= dcsr_pkg::FUNC_NOP;
			interrupt_enable_r <= 1'b0;
			unit_select_r      <= '0;
		end else if (csr_wr_en_in) begin
			function_code_r    <= wr_func_c;
			interrupt_enable_r <= csr_wr_data_in[dcsr_pkg::BIT_IE];
			unit_select_r      <= csr_wr_data_in[dcsr_pkg::BIT_UNIT_HI:
				dcsr_pkg::BIT_UNIT_LO];
		end
	end

	// software write beats a same-cycle carry
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			mem_hi_r <= '0;
		end else if (csr_wr_en_in) begin
			mem_hi_r <= csr_wr_data_in[dcsr_pkg::BIT_MEMHI_HI:
				dcsr_pkg::BIT_MEMHI_LO];
		end else if (ptr_carry_in) begin
			mem_hi_r <= mem_hi_r + dcsr_pkg::MEMHI_STEP;
		end
	end

	// completion sets ready and wins over a software clear
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			controller_idle_r <= dcsr_pkg::CTRL_IDLE_RST;
		end else if (cmd_done_in) begin
			controller_idle_r <= 1'b1;
		end else if (csr_wr_en_in) begin
			controller_idle_r <= csr_wr_data_in[dcsr_pkg::BIT_CTRL_IDLE];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			fault_code_r <= dcsr_pkg::FAULT_NONE;
		end else if (cmd_done_in) begin
			fault_code_r <= cmd_fault_code_in;
		end else if (go_c) begin
			fault_code_r <= dcsr_pkg::FAULT_NONE;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			seek_busy_r <= 1'b0;
		end else if (cmd_done_in) begin
			seek_busy_r <= 1'b0;
		end else if (go_c && wr_func_c == dcsr_pkg::FUNC_SEEK) begin
			seek_busy_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			cmd_start_r   <= 1'b0;
			fault_clear_r <= 1'b0;
			irq_r         <= 1'b0;
		end else begin
			cmd_start_r   <= go_c;
			fault_clear_r <= go_c && disk_address_bit3_in
				&& wr_func_c == dcsr_pkg::FUNC_GET_STATUS;
			irq_r         <= cmd_done_in && interrupt_enable_r
				&& !controller_idle_r;
		end
	end

	always_comb begin
		word_nxt = '0;
		word_nxt[dcsr_pkg::BIT_DRIVE_IDLE] = pins_clean[0]
			&& !seek_busy_r;
		word_nxt[dcsr_pkg::BIT_FUNC_HI:dcsr_pkg::BIT_FUNC_LO] =
			function_code_r;
		word_nxt[dcsr_pkg::BIT_MEMHI_HI:dcsr_pkg::BIT_MEMHI_LO] = mem_hi_r;
		word_nxt[dcsr_pkg::BIT_IE] = interrupt_enable_r;
		word_nxt[dcsr_pkg::BIT_CTRL_IDLE] = controller_idle_r;
		word_nxt[dcsr_pkg::BIT_UNIT_HI:dcsr_pkg::BIT_UNIT_LO] =
			unit_select_r;
		word_nxt[dcsr_pkg::BIT_FAULT_HI:dcsr_pkg::BIT_FAULT_LO] =
			fault_code_r;
		word_nxt[dcsr_pkg::BIT_DRIVE_ERR] = pins_clean[1];
		word_nxt[dcsr_pkg::BIT_ANY_ERR] = (|fault_code_r)
			|| pins_clean[1];
	end

	// read word lags state by one cycle so it comes from flip-flops
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= word_nxt;
		end
	end

	assign csr_rd_data_out       = rd_data_r;
	assign cmd_start_out         = cmd_start_r;
	assign function_code_out     = function_code_r;
	assign memory_pointer_hi_out = mem_hi_r;
	assign irq_request_out       = irq_r;
	assign controller_idle_out   = controller_idle_r;
	assign unit_select_out       = unit_select_r;
	assign drive_fault_clear_out = fault_clear_r;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	a_go_starts_cmd: assert property (
		go_c |=> cmd_start_out && !controller_idle_out
			&& function_code_out == $past(wr_func_c))
		else $error("go write did not start command");
	a_done_sets_idle: assert property (
		cmd_done_in |=> controller_idle_out && !cmd_start_out)
		else $error("ready not set after command end");
	a_irq_on_end: assert property (
		cmd_done_in && interrupt_enable_r && !controller_idle_r
			|=> irq_request_out)
		else $error("no interrupt at command end");
	a_irq_cause_only: assert property (
		irq_request_out |-> $past(interrupt_enable_r)
			&& $past(cmd_done_in) && controller_idle_out)
		else $error("interrupt without enabled command end");
	a_summary_error: assert property (
		##1 csr_rd_data_out[dcsr_pkg::BIT_ANY_ERR] ==
			|csr_rd_data_out[dcsr_pkg::BIT_DRIVE_ERR:
			dcsr_pkg::BIT_FAULT_LO])
		else $error("summary bit not OR of error bits");
	a_carry_hi_bits: assert property (
		ptr_carry_in && !csr_wr_en_in |=> memory_pointer_hi_out ==
			2'($past(memory_pointer_hi_out) + dcsr_pkg::MEMHI_STEP))
		else $error("pointer carry not added to high bits");
	a_status_kept: assert property (
		csr_wr_en_in && !cmd_done_in
			&& csr_wr_data_in[dcsr_pkg::BIT_CTRL_IDLE]
			|=> fault_code_r == $past(fault_code_r))
		else $error("write altered fault code");
	a_fault_capture: assert property (
		cmd_done_in |=> fault_code_r == $past(cmd_fault_code_in)
			##1 csr_rd_data_out[dcsr_pkg::BIT_FAULT_HI:
			dcsr_pkg::BIT_FAULT_LO] == $past(cmd_fault_code_in, 2))
		else $error("fault code not reported");
	a_unit_select: assert property (
		csr_wr_en_in |=> unit_select_out == $past(
			csr_wr_data_in[dcsr_pkg::BIT_UNIT_HI:dcsr_pkg::BIT_UNIT_LO]))
		else $error("unit select not taken");
	a_fault_clear: assert property (
		go_c && disk_address_bit3_in
			&& wr_func_c == dcsr_pkg::FUNC_GET_STATUS
			|=> drive_fault_clear_out ##1 !drive_fault_clear_out)
		else $error("drive fault clear not pulsed");
	a_seek_idle_low: assert property (
		go_c && wr_func_c == dcsr_pkg::FUNC_SEEK
			|=> ##1 !csr_rd_data_out[dcsr_pkg::BIT_DRIVE_IDLE])
		else $error("drive idle bit high during seek");
	a_init_state: assert property (
		$past(reset_in) |-> controller_idle_out && function_code_out == '0
			&& memory_pointer_hi_out == '0 && unit_select_out == '0
			&& !interrupt_enable_r && fault_code_r == '0)
		else $error("bad state after initialisation");
endmodule

//--- dcsr_drive_model.sv
/*
 * Drive bus partner: four drives, each with its own fault flag.
 * Assumes the controller clock and one-cycle clear pulses.
 */
`timescale 1ns/100ps
module dcsr_drive_model (
	// clock
	input  wire logic       ref_clk_in,
	// controller side
	input  wire logic [1:0] unit_select_in,
	input  wire logic       fault_clear_in,
	output logic            drive_idle_out,
	output logic            drive_fault_line_out,
	// bench control
	input  wire logic       fault_raise_in
);
	logic [3:0] fault_r;

	initial fault_r = 4'h0;
	// seeks finish at once, so the drive always shows ready
	assign drive_idle_out = 1'b1;
	// only the selected unit answers on the line
	assign drive_fault_line_out = fault_r[unit_select_in];
	always @(posedge ref_clk_in) begin
		if (fault_clear_in) begin
			fault_r[unit_select_in] <= 1'b0;
		end else if (fault_raise_in) begin
			fault_r[unit_select_in] <= 1'b1;
		end
	end
endmodule

//--- tb_top.sv
/*
 * Self-checking bench of the control/status word.
 * Assumes the drive model on the pins; inputs change on falling edges.
 */
`timescale 1ns/100ps
module tb_top;
	logic        ref_clk_in, reset_in, csr_wr_en_in, cmd_done_in;
	logic        ptr_carry_in, disk_address_bit3_in, cmd_start_out;
	logic        irq_request_out, controller_idle_out, drive_idle_in;
	logic        drive_fault_line_in, drive_fault_clear_out, fault_raise;
	logic [15:0] csr_wr_data_in, csr_rd_data_out, d, e, x;
	logic [3:0]  cmd_fault_code_in;
	logic [2:0]  function_code_out;
	logic [1:0]  memory_pointer_hi_out, unit_select_out;
	logic [31:0] seed_r;
	logic [15:0] start_q[$], irq_q[$], clr_q[$];
	logic [3:0]  flt[8] = '{4'h0, 4'h1, 4'h2, 4'h3,
		4'h4, 4'h5, 4'h8, 4'h9};
	int          n_errors, check_count;

	dcsr_control_status u_dut (
		.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.csr_wr_en_in(csr_wr_en_in), .csr_wr_data_in(csr_wr_data_in),
		.csr_rd_data_out(csr_rd_data_out), .cmd_done_in(cmd_done_in),
		.cmd_fault_code_in(cmd_fault_code_in), .ptr_carry_in(ptr_carry_in),
		.disk_address_bit3_in(disk_address_bit3_in),
		.cmd_start_out(cmd_start_out), .function_code_out(function_code_out),
		.memory_pointer_hi_out(memory_pointer_hi_out),
		.irq_request_out(irq_request_out),
		.controller_idle_out(controller_idle_out),
		.drive_idle_in(drive_idle_in), .unit_select_out(unit_select_out),
		.drive_fault_line_in(drive_fault_line_in),
		.drive_fault_clear_out(drive_fault_clear_out));
	dcsr_drive_model u_drive (
		.ref_clk_in(ref_clk_in), .unit_select_in(unit_select_out),
		.fault_clear_in(drive_fault_clear_out), .fault_raise_in(fault_raise),
		.drive_idle_out(drive_idle_in),
		.drive_fault_line_out(drive_fault_line_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// pins need several edges to pass the synchroniser
	task automatic rst;
		reset_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		reset_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check("reset word", csr_rd_data_out, 16'h0081);
	endtask
	task automatic wr(input logic [15:0] w);
		csr_wr_data_in = w;
		csr_wr_en_in = 1'b1;
		@(negedge ref_clk_in);
		csr_wr_en_in = 1'b0;
		@(negedge ref_clk_in);
	endtask
	task automatic done(input logic [3:0] c, input logic ie);
		cmd_fault_code_in = c;
		cmd_done_in = 1'b1;
		if (ie)
			irq_q.push_back(16'h1);
		@(negedge ref_clk_in);
		cmd_done_in = 1'b0;
		@(negedge ref_clk_in);
	endtask

	// results are matched against the oldest expectation
	always @(negedge ref_clk_in) begin
		if (!reset_in && cmd_start_out !== 1'b0) begin
			e = start_q.size() ? start_q.pop_front() : 16'hFFFF;
			check("start", function_code_out, e);
		end
		if (!reset_in && irq_request_out !== 1'b0) begin
			e = irq_q.size() ? irq_q.pop_front() : 16'h0;
			check("irq", 16'h1, e);
		end
		if (!reset_in && drive_fault_clear_out !== 1'b0) begin
			e = clr_q.size() ? clr_q.pop_front() : 16'h0;
			check("clear", 16'h1, e);
		end
	end

	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (3000) @(posedge ref_clk_in);
		n_errors++;
		report_and_stop();
	end
	initial begin
		{csr_wr_en_in, cmd_done_in, ptr_carry_in, fault_raise} = 4'h0;
		{csr_wr_data_in, cmd_fault_code_in, disk_address_bit3_in} = '0;
		seed_r = 32'h0000FD43;
		n_errors = 0;
		check_count = 0;
		rst();
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			seed_r = lfsr(seed_r);
			d = seed_r[15:0];
			d[7] = 1'b0;
			d[6] = i[0];
			d[3:1] = i[2:0];
			start_q.push_back(16'(i));
			wr(d);
			check("busy", controller_idle_out, 16'h0);
			check("drive idle", csr_rd_data_out[0], 16'(i != 3));
			check("unit", unit_select_out, d[9:8]);
			check("memhi", memory_pointer_hi_out, d[5:4]);
			done(flt[i], d[6]);
			x = {|flt[i], 1'b0, flt[i], d[9:8], 1'b1, d[6:1], 1'b1};
			check("word", csr_rd_data_out, x);
		end
		$display("command test done");
		wr(16'h00B0);
		ptr_carry_in = 1'b1;
		@(negedge ref_clk_in);
		ptr_carry_in = 1'b0;
		@(negedge ref_clk_in);
		check("carry", csr_rd_data_out[5:4], 16'h0);
		$display("carry test done");
		wr(16'h0280);
		fault_raise = 1'b1;
		@(negedge ref_clk_in);
		fault_raise = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check("fault bits", csr_rd_data_out[15:14], 16'h3);
		disk_address_bit3_in = 1'b1;
		start_q.push_back(16'h2);
		clr_q.push_back(16'h1);
		// get status with disk address bit 3 clears the drive fault
		wr(16'h0204);
		done(4'h0, 1'b0);
		repeat (6) @(negedge ref_clk_in);
		check("cleared", csr_rd_data_out, 16'h0285);
		$display("drive fault test done");
		rst();
		x = 16'(start_q.size() + irq_q.size() + clr_q.size());
		check("queues", x, 16'h0);
		$display("second reset test done");
		report_and_stop();
	end
endmodule
